// file: core/spcw_pkg.sv
// Package: register map, field positions, reset values and bus carriers for the serial block
package spcw_pkg;

  localparam int unsigned ADDR_W = 5;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_DATA = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_STAT = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_PWR  = 5'h0C;

  // Control register fields
  localparam int unsigned CB_IE    = 7;
  localparam int unsigned CB_PE    = 6;
  localparam int unsigned CB_DIVHI = 5;
  localparam int unsigned CB_ROLE  = 4;
  localparam int unsigned CB_IDLE_CLOCK_LEVEL  = 3;
  localparam int unsigned CB_CAPTURE_EDGE_SELECT  = 2;
  localparam int unsigned CB_RATE1 = 1;
  localparam int unsigned CB_RATE0 = 0;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // Serial clock dividers of the clock rate, indexed by {hi, lo[1:0]}
  localparam logic [7:0] DIV_100 = 8'h04;
  localparam logic [7:0] DIV_000 = 8'h08;
  localparam logic [7:0] DIV_001 = 8'h10;
  localparam logic [7:0] DIV_110 = 8'h20;
  localparam logic [7:0] DIV_010 = 8'h40;
  localparam logic [7:0] DIV_011 = 8'h80;

  // Last edge index of the 16 edges in one byte
  localparam logic [4:0] LAST_EDGE = 5'h0F;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } spcw_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } spcw_axi_rsp_t;

endpackage : spcw_pkg

// file: core/spcw_core.sv
// Serial peripheral control, flags, low-power wake-up and register slave
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module spcw_core
  import spcw_pkg::*;
(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire spcw_axi_req_t axi_req,
  output var  spcw_axi_rsp_t axi_rsp,
  input  wire logic          sck_i,
  output logic               sck_o,
  output logic               sck_oe,
  input  wire logic          mosi_i,
  output logic               mosi_o,
  output logic               mosi_oe,
  input  wire logic          miso_i,
  output logic               miso_o,
  output logic               miso_oe,
  input  wire logic          ss_n_i,
  input  wire logic          halt_mode,
  input  wire logic          wait_mode,
  output logic               irq,
  output logic               wake_wait,
  output logic               clock_restart_req
);

  typedef struct packed {
    logic [7:0]        ctrl;
    logic              transfer_done_flag;
    logic              wcol;
    logic              overflow_flag;
    logic              role_fault_flag;
    logic              sod;
    logic              ssm;
    logic              soft_select_level;
    logic              stat_seen;
    logic              role_fault_flag_seen;
    logic [7:0]        shift;
    logic [7:0]        rxbuf;
    logic              dout;
    logic [4:0]        edge_cnt;
    logic [6:0]        div_cnt;
    logic              sck;
    logic              sck_prev;
    logic              busy;
    logic              halt_prev;
    logic              armed;
    logic              halt_state;
    logic              wake_halt;
    logic              wake_wait;
    logic              irq;
    logic              sck_oe;
    logic              mosi_oe;
    logic              miso_oe;
    logic              aw_have;
    logic              w_have;
    logic [ADDR_W-1:0] waddr;
    logic [7:0]        wdata;
    logic              wen;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [7:0]        rdata;
    logic [1:0]        rresp;
  } spcw_state_t;

  spcw_state_t state_ff;
  spcw_state_t nxt_state;
  logic        done_evt;
  logic        ss_int;

  // Master half period in clock cycles
  function automatic logic [6:0] half_period(input logic [2:0] sel);
    logic [7:0] div;
    begin
      div = DIV_100;
      unique case (sel)
        3'h4: div = DIV_100;
        3'h0: div = DIV_000;
        3'h1: div = DIV_001;
        3'h6: div = DIV_110;
        3'h2: div = DIV_010;
        3'h3: div = DIV_011;
        default: div = DIV_100;
      endcase
      half_period = div[7:1];
    end
  endfunction : half_period

  always_comb begin
    spcw_state_t n;
    logic        run;
    logic        edge_hit;
    logic        eng;
    logic [6:0]  half;
    n        = state_ff;
    done_evt = 1'b0;
    edge_hit = 1'b0;
    run      = !halt_mode;
    eng      = 1'b0;
    half     = 7'h00;
    ss_int = state_ff.ssm ? state_ff.soft_select_level : ss_n_i;

    // Write address and data handshakes are always taken into holding registers; reads are taken only outside halt
    if (axi_req.awvalid && state_ff.awready) begin
      n.aw_have = 1'b1;
      n.waddr   = axi_req.awaddr;
    end
    if (axi_req.wvalid && state_ff.wready) begin
      n.w_have = 1'b1;
      n.wdata  = axi_req.wdata[7:0];
      n.wen    = axi_req.wstrb[0];
    end
    if (state_ff.bvalid && axi_req.bready) begin
      n.bvalid = 1'b0;
    end
    if (state_ff.rvalid && axi_req.rready) begin
      n.rvalid = 1'b0;
    end

    if (run && state_ff.aw_have && state_ff.w_have && !state_ff.bvalid) begin
      n.aw_have = 1'b0;
      n.w_have  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = RESP_OKAY;
      unique case (state_ff.waddr)
        OFS_DATA: if (state_ff.wen) begin
          if (state_ff.transfer_done_flag && !state_ff.stat_seen) begin
            n.transfer_done_flag = state_ff.transfer_done_flag;
          end else if (state_ff.busy) begin
            n.wcol = 1'b1;
          end else begin
            n.shift = state_ff.wdata;
            n.dout  = state_ff.wdata[7];
            n.busy  = state_ff.ctrl[CB_ROLE] && state_ff.ctrl[CB_PE];
          end
          if (state_ff.stat_seen) begin
            n.transfer_done_flag      = 1'b0;
            n.wcol      = 1'b0;
            n.stat_seen = 1'b0;
          end
        end
        OFS_CTRL: if (state_ff.wen) begin
          n.ctrl = state_ff.wdata;
          if (state_ff.role_fault_flag && state_ff.role_fault_flag_seen) begin
            n.role_fault_flag      = 1'b0;
            n.role_fault_flag_seen = 1'b0;
          end else if (state_ff.role_fault_flag) begin
            n.ctrl[CB_PE]   = 1'b0;
            n.ctrl[CB_ROLE] = 1'b0;
          end
        end
        OFS_STAT: if (state_ff.wen) begin
          n.sod = state_ff.wdata[2];
          n.ssm = state_ff.wdata[1];
          n.soft_select_level = state_ff.wdata[0];
        end
        OFS_PWR: n.bresp = RESP_OKAY;
        default: n.bresp = RESP_SLVERR;
      endcase
    end

    if (run && axi_req.arvalid && state_ff.arready) begin
      n.rvalid = 1'b1;
      n.rresp  = RESP_OKAY;
      n.rdata  = BYTE_RST;
      unique case (axi_req.araddr)
        OFS_DATA: begin
          n.rdata = state_ff.rxbuf;
          if (state_ff.stat_seen) begin
            n.transfer_done_flag      = 1'b0;
            n.wcol      = 1'b0;
            n.stat_seen = 1'b0;
          end
        end
        OFS_CTRL: n.rdata = state_ff.ctrl;
        OFS_STAT: begin
          n.rdata = {state_ff.transfer_done_flag, state_ff.wcol, state_ff.overflow_flag, state_ff.role_fault_flag,
                     1'b0, state_ff.sod, state_ff.ssm, state_ff.soft_select_level};
          n.overflow_flag       = 1'b0;
          n.stat_seen = state_ff.transfer_done_flag || state_ff.wcol;
          n.role_fault_flag_seen = state_ff.role_fault_flag;
        end
        OFS_PWR: n.rdata = {6'h00, state_ff.armed, state_ff.halt_state};
        default: n.rresp = RESP_SLVERR;
      endcase
    end

    n.halt_prev = halt_mode;
    if (halt_mode && !state_ff.halt_prev) begin
      n.armed = !ss_int;
    end
    eng = run || (state_ff.armed && !state_ff.ctrl[CB_ROLE] && state_ff.ctrl[CB_PE]);

    // mode fault drops master role and port enable
    if (run && state_ff.ctrl[CB_ROLE] && !ss_int) begin
      n.role_fault_flag          = 1'b1;
      n.ctrl[CB_PE]   = 1'b0;
      n.ctrl[CB_ROLE] = 1'b0;
      n.busy          = 1'b0;
      n.edge_cnt      = 5'h00;
    end else if (eng && state_ff.ctrl[CB_PE]) begin
      n.sck_prev = sck_i;
      if (state_ff.ctrl[CB_ROLE]) begin
        half = half_period({state_ff.ctrl[CB_DIVHI], state_ff.ctrl[CB_RATE1],
                            state_ff.ctrl[CB_RATE0]});
        if (state_ff.busy) begin
          n.div_cnt = state_ff.div_cnt + 7'h01;
          if (state_ff.div_cnt == half - 7'h01) begin
            n.div_cnt = 7'h00;
            n.sck     = !state_ff.sck;
            edge_hit  = 1'b1;
          end
        end
      end else if (ss_int) begin
        n.busy     = 1'b0;
        n.edge_cnt = 5'h00;
        n.dout     = n.shift[7];
      end else if (sck_i != state_ff.sck_prev) begin
        edge_hit = 1'b1;
        n.busy   = 1'b1;
      end
      if (edge_hit) begin
        if (state_ff.edge_cnt[0] == state_ff.ctrl[CB_CAPTURE_EDGE_SELECT]) begin
          n.shift = {state_ff.shift[6:0], state_ff.ctrl[CB_ROLE] ? miso_i : mosi_i};
        end else begin
          n.dout = state_ff.shift[7];
        end
        n.edge_cnt = state_ff.edge_cnt + 5'h01;
        if (state_ff.edge_cnt == LAST_EDGE) begin
          // shift register keeps the received byte for return
          done_evt   = 1'b1;
          n.busy     = 1'b0;
          n.edge_cnt = 5'h00;
          n.div_cnt  = 7'h00;
          if (state_ff.transfer_done_flag) begin
            n.overflow_flag = 1'b1;
          end else begin
            n.rxbuf = n.shift;
            n.transfer_done_flag  = 1'b1;
          end
        end
      end
    end

    // idle clock level in both roles
    if (!n.busy) begin
      n.sck = n.ctrl[CB_IDLE_CLOCK_LEVEL];
    end

    // halt wake, then clock restart request
    if (halt_mode && done_evt) begin
      n.wake_halt  = 1'b1;
      n.halt_state = 1'b1;
    end else if (!halt_mode) begin
      n.wake_halt = 1'b0;
      n.armed     = 1'b0;
      // leaving slave role ends halt state
      if (done_evt || n.ctrl[CB_ROLE] || !n.ctrl[CB_PE]) begin
        n.halt_state = 1'b0;
      end
    end

    n.irq       = n.ctrl[CB_IE] && (n.transfer_done_flag || n.role_fault_flag || n.overflow_flag) && !halt_mode;
    // wait wake-up on any enabled event
    n.wake_wait = n.ctrl[CB_IE] && (n.transfer_done_flag || n.role_fault_flag || n.overflow_flag) && wait_mode;

    // pin directions follow role and port enable
    n.sck_oe  = n.ctrl[CB_PE] && n.ctrl[CB_ROLE];
    n.mosi_oe = n.ctrl[CB_PE] && n.ctrl[CB_ROLE] && !n.sod;
    n.miso_oe = n.ctrl[CB_PE] && !n.ctrl[CB_ROLE] && !n.sod && !ss_int;

    n.awready   = !n.aw_have && !n.bvalid;
    n.wready    = !n.w_have && !n.bvalid;
    n.arready   = !n.rvalid;
    nxt_state   = n;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff      <= '0;
      state_ff.ctrl <= CTRL_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign axi_rsp.awready   = state_ff.awready;
  assign axi_rsp.wready    = state_ff.wready;
  assign axi_rsp.bvalid    = state_ff.bvalid;
  assign axi_rsp.bresp     = state_ff.bresp;
  assign axi_rsp.arready   = state_ff.arready;
  assign axi_rsp.rvalid    = state_ff.rvalid;
  assign axi_rsp.rdata     = {24'h000000, state_ff.rdata};
  assign axi_rsp.rresp     = state_ff.rresp;
  assign sck_o             = state_ff.sck;
  assign sck_oe            = state_ff.sck_oe;
  assign mosi_o            = state_ff.dout;
  assign mosi_oe           = state_ff.mosi_oe;
  assign miso_o            = state_ff.dout;
  assign miso_oe           = state_ff.miso_oe;
  assign irq               = state_ff.irq;
  assign wake_wait         = state_ff.wake_wait;
  assign clock_restart_req = state_ff.wake_halt;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Checks on the behaviour above
  mode_fault_drop_a: assert property (
    !halt_mode && state_ff.ctrl[CB_ROLE] && !ss_int
    |=> state_ff.role_fault_flag && !state_ff.ctrl[CB_ROLE] && !state_ff.ctrl[CB_PE] && !sck_oe)
    else $error("mode fault did not drop master role");
  irq_inhibit_a: assert property (
    !state_ff.ctrl[CB_IE] && !nxt_state.ctrl[CB_IE] |=> !irq ##1 !irq)
    else $error("interrupt raised while disabled");
  ovr_on_busy_a: assert property (
    done_evt && state_ff.transfer_done_flag |=> state_ff.overflow_flag && $stable(state_ff.rxbuf))
    else $error("overflow not flagged");
  halt_frozen_a: assert property (
    halt_mode && $past(halt_mode) && !state_ff.armed
    |=> $stable(state_ff.transfer_done_flag) && $stable(state_ff.shift) && $stable(state_ff.overflow_flag))
    else $error("registers changed in halt");
  wait_exit_a: assert property (
    wait_mode && state_ff.ctrl[CB_IE] && state_ff.role_fault_flag && !halt_mode
    && nxt_state.ctrl[CB_IE] && nxt_state.role_fault_flag ##1 wait_mode |-> wake_wait)
    else $error("no wait wake-up");
  halt_wake_a: assert property (
    halt_mode && done_evt |=> clock_restart_req && !irq && state_ff.transfer_done_flag)
    else $error("halt wake sequence wrong");
  unarmed_halt_a: assert property (
    halt_mode && $past(halt_mode) && !state_ff.armed |=> !$rose(clock_restart_req))
    else $error("wake from halt without arming");
  fast_rate_a: assert property (
    $changed(sck_o) && state_ff.busy && state_ff.ctrl[CB_ROLE]
    && {state_ff.ctrl[CB_DIVHI], state_ff.ctrl[CB_RATE1], state_ff.ctrl[CB_RATE0]} == 3'h4
    && !halt_mode |=> !$changed(sck_o))
    else $error("master clock half period too short");
  idle_level_a: assert property (
    !state_ff.busy |-> sck_o == state_ff.ctrl[CB_IDLE_CLOCK_LEVEL])
    else $error("clock idle level wrong");
  role_leave_a: assert property (
    state_ff.halt_state && !halt_mode && nxt_state.ctrl[CB_ROLE] |=> !state_ff.halt_state)
    else $error("halt state kept after leaving slave role");

  master_done_c: cover property (done_evt && state_ff.ctrl[CB_ROLE]);
  slave_wake_c: cover property (halt_mode && done_evt);
  mode_fault_c: cover property ($rose(state_ff.role_fault_flag));
  overrun_c: cover property ($rose(state_ff.overflow_flag));

endmodule : spcw_core

`default_nettype wire

// file: dv/spcw_peer.sv
// Far-side serial master model driving select, clock and data
`timescale 1ns/100ps
`default_nettype none

module spcw_peer (
  input  wire logic clk,
  output logic      sck,
  output logic      mosi,
  output logic      ss_n,
  input  wire logic miso_o,
  input  wire logic miso_oe
);
  localparam int H = 4;
  logic last;

  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    ss_n = 1'b1;
    last = 1'b0;
  end

  task sel(input logic l, input logic cp);
    @(posedge clk);
    ss_n <= l;
    sck <= cp;
    repeat (H) @(posedge clk);
  endtask : sel

  // same clock settings as the slave
  task xfer(input int m, input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      if (m[0]) sck <= ~sck;
      mosi <= d[i];
      repeat (H) @(posedge clk);
      q[i] = miso_oe ? miso_o : ~last;
      last = q[i];
      sck <= ~sck;
      repeat (H) @(posedge clk);
      if (!m[0]) sck <= ~sck;
    end
    repeat (H) @(posedge clk);
    mosi <= ~mosi;
  endtask : xfer
endmodule : spcw_peer

`default_nettype wire

// file: dv/tb_top.sv
// Register-level testbench of the serial control block
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import spcw_pkg::*;
  logic          aclk, aresetn, halt_mode, wait_mode;
  spcw_axi_req_t rq;
  spcw_axi_rsp_t rs;
  logic          sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic          irq, wake_wait, clock_restart_req;
  logic          p_sck, p_mosi, p_ss, sck_w, mosi_w;
  logic [7:0]    rdv, pg;
  logic [1:0]    rsv;
  int            n_errors, n_compared, n;
  int            cyc = 0;
  logic [2:0]    cd [6] = '{3'h4, 3'h0, 3'h1, 3'h6, 3'h2, 3'h3};
  int            dv [6] = '{4, 8, 16, 32, 64, 128};

  assign sck_w = sck_oe ? sck_o : p_sck;
  assign mosi_w = mosi_oe ? mosi_o : p_mosi;

  spcw_core DUT (.aclk, .aresetn, .axi_req(rq), .axi_rsp(rs), .sck_i(sck_w), .sck_o,
    .sck_oe, .mosi_i(mosi_w), .mosi_o, .mosi_oe, .miso_i(mosi_w), .miso_o, .miso_oe,
    .ss_n_i(p_ss), .halt_mode, .wait_mode, .irq, .wake_wait, .clock_restart_req);

  spcw_peer peer (.clk(aclk), .sck(p_sck), .mosi(p_mosi), .ss_n(p_ss), .miso_o,
    .miso_oe);

  initial aclk = 1'b0;
  always #50 aclk = ~aclk;

  task stop_test;
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      stop_test();
    end
  end

  task chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk

  task wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge aclk);
    rq.awaddr <= a;
    rq.wdata <= {24'h0, d};
    rq.wstrb <= 4'hF;
    rq.awvalid <= 1'b1;
    rq.wvalid <= 1'b1;
    rq.bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (rs.awready) rq.awvalid <= 1'b0;
      if (rs.wready) rq.wvalid <= 1'b0;
    end while (rs.bvalid !== 1'b1);
    rsv = rs.bresp;
    rq.bready <= 1'b0;
  endtask : wr

  task rd(input logic [4:0] a);
    @(posedge aclk);
    rq.araddr <= a;
    rq.arvalid <= 1'b1;
    rq.rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (rs.arready) rq.arvalid <= 1'b0;
    end while (rs.rvalid !== 1'b1);
    rdv = rs.rdata[7:0];
    rsv = rs.rresp;
    rq.rready <= 1'b0;
  endtask : rd

  task sx(input int m, input logic [7:0] d);
    peer.sel(1'b0, m[1]);
    peer.xfer(m, d, pg);
    peer.sel(1'b1, m[1]);
  endtask : sx

  task tick(input int k);
    repeat (k) @(posedge aclk);
  endtask : tick

  initial begin
    rq = '0;
    aresetn = 1'b0;
    halt_mode = 1'b0;
    wait_mode = 1'b0;
    n_errors = 0;
    n_compared = 0;
    tick(2);
    aresetn <= 1'b1;
    rd(OFS_CTRL);
    chk(rdv, 8'h00);
    wr(OFS_CTRL, 8'h2F);
    rd(OFS_CTRL);
    chk(rdv, 8'h2F);
    rd(5'h10);
    chk(8'(rsv), 8'h02);
    $display("register test done");
    wr(OFS_STAT, 8'h03);
    for (int i = 0; i < 6; i++) begin
      wr(OFS_CTRL, {2'h3, cd[i][2], 3'h4, cd[i][1:0]});
      wr(OFS_DATA, 8'hA5);
      n = 0;
      while (sck_o !== 1'b1) @(posedge aclk);
      while (sck_o === 1'b1) begin
        @(posedge aclk);
        n++;
      end
      chk(8'(n), 8'(dv[i] / 2));
      chk(8'(sck_oe), 8'h01);
      do rd(OFS_STAT); while (rdv[7] !== 1'b1);
      chk(8'(irq), 8'h01);
      rd(OFS_DATA);
      chk(rdv, 8'hA5);
    end
    wr(OFS_CTRL, 8'h00);
    wr(OFS_CTRL, 8'h58);
    tick(3);
    chk(8'(sck_o), 8'h01);
    $display("master rate test done");
    wr(OFS_STAT, 8'h00);
    wr(OFS_CTRL, 8'hD0);
    peer.sel(1'b0, 1'b0);
    rd(OFS_CTRL);
    chk(rdv, 8'h80);
    rd(OFS_STAT);
    chk(rdv, 8'h10);
    chk(8'(irq), 8'h01);
    wait_mode <= 1'b1;
    tick(3);
    chk(8'(wake_wait), 8'h01);
    wait_mode <= 1'b0;
    wr(OFS_CTRL, 8'h00);
    peer.sel(1'b1, 1'b0);
    rd(OFS_STAT);
    chk(rdv, 8'h00);
    $display("mode fault test done");
    for (int m = 0; m < 4; m++) begin
      wr(OFS_CTRL, 8'h00);
      wr(OFS_CTRL, 8'h63 | 8'(m << 2));
      wr(OFS_DATA, 8'h3C ^ 8'(m));
      sx(m, 8'hC5 + 8'(m));
      chk(pg, 8'h3C ^ 8'(m));
      rd(OFS_STAT);
      chk(rdv, 8'h80);
      rd(OFS_DATA);
      chk(rdv, 8'hC5 + 8'(m));
    end
    sx(3, 8'h5A);
    chk(pg, 8'hC8);
    sx(3, 8'h77);
    rd(OFS_STAT);
    chk(rdv, 8'hA0);
    rd(OFS_DATA);
    $display("slave test done");
    wr(OFS_CTRL, 8'h00);
    wr(OFS_CTRL, 8'hC4);
    peer.sel(1'b0, 1'b0);
    halt_mode <= 1'b1;
    tick(2);
    peer.xfer(1, 8'h11, pg);
    tick(2);
    chk(8'(clock_restart_req), 8'h01);
    chk(8'(irq), 8'h00);
    peer.xfer(1, 8'h22, pg);
    halt_mode <= 1'b0;
    tick(3);
    chk(8'(irq), 8'h01);
    rd(OFS_STAT);
    chk(rdv, 8'hA0);
    rd(OFS_DATA);
    chk(rdv, 8'h11);
    rd(OFS_PWR);
    chk(rdv & 8'h01, 8'h01);
    peer.xfer(1, 8'h44, pg);
    rd(OFS_PWR);
    chk(rdv & 8'h01, 8'h00);
    peer.sel(1'b1, 1'b0);
    halt_mode <= 1'b1;
    tick(2);
    peer.xfer(1, 8'h33, pg);
    chk(8'(clock_restart_req), 8'h00);
    halt_mode <= 1'b0;
    $display("halt test done");
    stop_test();
  end
endmodule : tb_top

`default_nettype wire
